// ---- design/spi_port_pkg.sv ----
// Constants, register map and carrier types for the serial port block.
// Assumes a 125 MHz system clock and a 32-bit APB register bus.
package spi_port_pkg;

    // Register bus geometry
    localparam int          APB_ADDR_W        = 8;
    localparam int          DATA_W            = 8;

    // Register byte offsets
    localparam logic [7:0]  OFS_CONTROL_ZERO  = 8'h00;
    localparam logic [7:0]  OFS_CONTROL_ONE   = 8'h04;
    localparam logic [7:0]  OFS_SHIFT_DATA    = 8'h08;

    // control_register_zero fields
    localparam int          MODE_LSB          = 5;
    localparam int          PORT_ENABLE_BIT   = 1;

    // control_register_one fields
    localparam int          CLK_IDLE_POL_BIT  = 5;
    localparam int          CLK_EDGE_BIT      = 4;
    localparam int          BIT_ORDER_BIT     = 3;
    localparam int          SELECT_EN_BIT     = 2;
    localparam int          WCOL_BIT          = 1;
    localparam int          TRF_BIT           = 0;

    // Values after reset
    localparam logic [7:0]  RST_CONTROL_ZERO  = 8'h00;
    localparam logic [7:0]  RST_CONTROL_ONE   = 8'h00;
    localparam logic [7:0]  RST_SHIFT_DATA    = 8'h00;

    // Mode field: bit 2 set selects slave, else master with divider below
    localparam int          MODE_SLAVE_BIT    = 2;

    // Half period of the master serial clock in system cycles, per mode
    // Fastest rate still leaves the three-stage input synchroniser time to settle
    localparam logic [7:0]  HALF_DIV_0        = 8'h06;
    localparam logic [7:0]  HALF_DIV_1        = 8'h08;
    localparam logic [7:0]  HALF_DIV_2        = 8'h20;
    localparam logic [7:0]  HALF_DIV_3        = 8'h80;

    // Index of the last bit and of the last serial clock edge of a transfer
    localparam logic [2:0]  LAST_BIT          = 3'h7;
    localparam logic [3:0]  LAST_EDGE         = 4'hF;

    typedef enum logic [1:0] {
        XFER_IDLE = 2'b01,
        XFER_BUSY = 2'b10
    } xfer_e;

    typedef struct packed {
        logic       clock_idle_polarity;
        logic       clock_edge_select;
        logic       bit_order_select;
        logic       select_pin_enable;
        logic       write_collision_flag;
        logic       transfer_complete_flag;
    } control_one_s;

endpackage : spi_port_pkg

// ---- design/pin_sync.sv ----
// Three-stage synchroniser for pins from outside the system clock domain.
// A level change counts once the second and third stages agree.
`timescale 1ns/1ns
module pin_sync #(
    parameter int          WIDTH  = 3,
    parameter logic [2:0]  RESET  = 3'h7
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] level_o,
    output logic      [WIDTH-1:0] rise_o,
    output logic      [WIDTH-1:0] fall_o
);

    initial begin
        if (WIDTH < 1 || WIDTH > 3) $error("pin_sync WIDTH must be 1 to 3");
    end

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic stage1;
            logic stage2;
            logic stage3;
            always_ff @(posedge sys_clk_i) begin
                if (!rst_n_i) begin
                    stage1     <= RESET[g];
                    stage2     <= RESET[g];
                    stage3     <= RESET[g];
                    level_o[g] <= RESET[g];
                    rise_o[g]  <= 1'b0;
                    fall_o[g]  <= 1'b0;
                end else begin
                    stage1     <= pin_i[g];
                    stage2     <= stage1;
                    stage3     <= stage2;
                    // Stage one feeds stage two only, for metastability
                    if (stage2 == stage3) begin
                        level_o[g] <= stage3;
                    end
                    rise_o[g]  <= (stage2 == stage3) &&  stage3 && !level_o[g];
                    fall_o[g]  <= (stage2 == stage3) && !stage3 &&  level_o[g];
                end
            end
        end
    endgenerate

endmodule : pin_sync

// ---- design/half_tick.sv ----
// Tick generator for the master serial clock half periods.
// Counting restarts whenever run_i drops, so each transfer starts clean.
`timescale 1ns/1ns
module half_tick #(
    parameter int W = 8
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         run_i,
    input  wire logic [W-1:0] half_i,
    output logic              tick_o
);

    logic [W-1:0] count;

    initial begin
        if (W < 2) $error("half_tick W must be at least 2");
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            count  <= '0;
            tick_o <= 1'b0;
        end else if (!run_i || tick_o) begin
            count  <= '0;
            tick_o <= 1'b0;
        end else begin
            count  <= count + W'(1);
            tick_o <= (count == half_i - W'(2));
        end
    end

endmodule : half_tick

// ---- design/spi_master_slave_port.sv ----
// Serial port that works as SPI master or slave, with APB registers.
// Assumes pins are three-signal (in, out, enable); the bench resolves wires.
// How it works
// - Bit three of control one picks LSB first (0) or MSB first (1).
// - Bit two enables the select pin and the port; zero floats select.
// - Data write during a transfer is dropped and sets the collision flag.
// - Complete flag reads zero during a transfer, sets when it finishes.
// - An interrupt request follows the transfer complete flag.
// - Master: a data write while enabled starts a full-duplex transfer.
// - Slave: external clock pulses shift data out and in.
// - Disabled port releases all four pins.
// - Enabled port floats serial input and drives serial output high idle, except a selected leading-capture slave shows its first bit.
// - Master idle clock level is the inverse of the polarity bit.
// - Slave never drives the serial clock pin.
// - Master alone makes the clock, only after a data write.
// - Received bits reach the readable data register only when complete.
// - Three-bit mode field picks master with clock rate, or slave.
// - Slave transfer needs select enable high and select low, then a leading clock edge.
// - Polarity zero idles the clock high, one idles it low.
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ns
module spi_master_slave_port (
    input  wire logic                              sys_clk_i,
    input  wire logic                              rst_n_i,
    input  wire logic                              psel_i,
    input  wire logic                              penable_i,
    input  wire logic                              pwrite_i,
    input  wire logic [spi_port_pkg::APB_ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]                       pwdata_i,
    output logic      [31:0]                       prdata_o,
    output logic                                   pready_o,
    output logic                                   pslverr_o,
    input  wire logic                              serial_clock_pin_i,
    output logic                                   serial_clock_pin_o,
    output logic                                   serial_clock_pin_oe_o,
    input  wire logic                              serial_in_pin_i,
    output logic                                   serial_out_pin_o,
    output logic                                   serial_out_pin_oe_o,
    input  wire logic                              select_pin_n_i,
    output logic                                   select_pin_n_o,
    output logic                                   select_pin_n_oe_o,
    output logic                                   irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [2:0]                mode_clock_select;
    logic                      port_enable;
    spi_port_pkg::control_one_s ctl;
    logic [7:0]                shift_data_register;
    logic [7:0]                shift_buffer;
    spi_port_pkg::xfer_e       state;
    logic [2:0]                bit_cnt;
    logic [3:0]                edge_cnt;
    logic                      master_tick;
    logic [2:0]                pin_level;
    logic [2:0]                pin_rise;
    logic [2:0]                pin_fall;
    logic [7:0]                half_period;
    logic                      access;
    logic                      write_fire;
    logic                      addr_hit;
    logic [31:0]               read_mux;
    logic                      port_on;
    logic                      is_slave;
    logic                      busy;
    logic                      cap_lead;
    logic                      slave_armed;
    logic                      slave_lead;
    logic                      slave_trail;
    logic                      lead_ev;
    logic                      trail_ev;
    logic                      sample_ev;
    logic                      launch_ev;
    logic                      slave_go;
    logic                      data_write;
    logic                      ctl1_write;
    logic                      start;
    logic                      collide;
    logic                      done;
    logic                      abort;
    logic [7:0]                next_shift;
    logic                      head_bit;
    logic                      start_head;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: bit 0 clock, bit 1 serial in, bit 2 select
    pin_sync #(
        .WIDTH (3),
        .RESET (3'h7)
    ) u_pin_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .pin_i     ({select_pin_n_i, serial_in_pin_i, serial_clock_pin_i}),
        .level_o   (pin_level),
        .rise_o    (pin_rise),
        .fall_o    (pin_fall)
    );

    always_comb begin
        case (mode_clock_select[1:0])
            2'h0:    half_period = spi_port_pkg::HALF_DIV_0;
            2'h1:    half_period = spi_port_pkg::HALF_DIV_1;
            2'h2:    half_period = spi_port_pkg::HALF_DIV_2;
            default: half_period = spi_port_pkg::HALF_DIV_3;
        endcase
    end

    half_tick #(
        .W (8)
    ) u_half_tick (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (busy && !is_slave),
        .half_i    (half_period),
        .tick_o    (master_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, pslverr on unmapped offsets
    assign access     = psel_i && penable_i && !pready_o;
    assign write_fire = psel_i && penable_i && pready_o && pwrite_i && addr_hit;
    assign addr_hit   = (paddr_i == spi_port_pkg::OFS_CONTROL_ZERO) ||
                        (paddr_i == spi_port_pkg::OFS_CONTROL_ONE) ||
                        (paddr_i == spi_port_pkg::OFS_SHIFT_DATA);
    assign data_write = write_fire && (paddr_i == spi_port_pkg::OFS_SHIFT_DATA);
    assign ctl1_write = write_fire && (paddr_i == spi_port_pkg::OFS_CONTROL_ONE);

    always_comb begin
        read_mux = 32'h0000_0000;
        case (paddr_i)
            spi_port_pkg::OFS_CONTROL_ZERO: begin
                read_mux[spi_port_pkg::MODE_LSB +: 3]       = mode_clock_select;
                read_mux[spi_port_pkg::PORT_ENABLE_BIT]     = port_enable;
            end
            spi_port_pkg::OFS_CONTROL_ONE: begin
                read_mux[spi_port_pkg::CLK_IDLE_POL_BIT]    = ctl.clock_idle_polarity;
                read_mux[spi_port_pkg::CLK_EDGE_BIT]        = ctl.clock_edge_select;
                read_mux[spi_port_pkg::BIT_ORDER_BIT]       = ctl.bit_order_select;
                read_mux[spi_port_pkg::SELECT_EN_BIT]       = ctl.select_pin_enable;
                read_mux[spi_port_pkg::WCOL_BIT]            = ctl.write_collision_flag;
                read_mux[spi_port_pkg::TRF_BIT]             = ctl.transfer_complete_flag;
            end
            spi_port_pkg::OFS_SHIFT_DATA: read_mux[7:0] = shift_data_register;
            default:                      read_mux      = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= access;
            pslverr_o <= access && !addr_hit;
            prdata_o  <= (access && !pwrite_i) ? read_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mode_clock_select <= spi_port_pkg::RST_CONTROL_ZERO[spi_port_pkg::MODE_LSB +: 3];
            port_enable       <= spi_port_pkg::RST_CONTROL_ZERO[spi_port_pkg::PORT_ENABLE_BIT];
        end else if (write_fire && paddr_i == spi_port_pkg::OFS_CONTROL_ZERO) begin
            mode_clock_select <= pwdata_i[spi_port_pkg::MODE_LSB +: 3];
            port_enable       <= pwdata_i[spi_port_pkg::PORT_ENABLE_BIT];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ctl.clock_idle_polarity <= spi_port_pkg::RST_CONTROL_ONE[spi_port_pkg::CLK_IDLE_POL_BIT];
            ctl.clock_edge_select   <= spi_port_pkg::RST_CONTROL_ONE[spi_port_pkg::CLK_EDGE_BIT];
            ctl.bit_order_select    <= spi_port_pkg::RST_CONTROL_ONE[spi_port_pkg::BIT_ORDER_BIT];
            ctl.select_pin_enable   <= spi_port_pkg::RST_CONTROL_ONE[spi_port_pkg::SELECT_EN_BIT];
        end else if (ctl1_write) begin
            ctl.clock_idle_polarity <= pwdata_i[spi_port_pkg::CLK_IDLE_POL_BIT];
            ctl.clock_edge_select   <= pwdata_i[spi_port_pkg::CLK_EDGE_BIT];
            ctl.bit_order_select    <= pwdata_i[spi_port_pkg::BIT_ORDER_BIT];
            ctl.select_pin_enable   <= pwdata_i[spi_port_pkg::SELECT_EN_BIT];
        end
    end

    // Flags: a hardware set wins over a software clear in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ctl.write_collision_flag   <= spi_port_pkg::RST_CONTROL_ONE[spi_port_pkg::WCOL_BIT];
            ctl.transfer_complete_flag <= spi_port_pkg::RST_CONTROL_ONE[spi_port_pkg::TRF_BIT];
            irq_o                      <= 1'b0;
        end else begin
            ctl.write_collision_flag <= collide || (ctl.write_collision_flag &&
                                        !(ctl1_write && !pwdata_i[spi_port_pkg::WCOL_BIT]));
            ctl.transfer_complete_flag <= done || (ctl.transfer_complete_flag && !start && !slave_go &&
                                          !(ctl1_write && !pwdata_i[spi_port_pkg::TRF_BIT]));
            irq_o <= done || (ctl.transfer_complete_flag && !start && !slave_go &&
                     !(ctl1_write && !pwdata_i[spi_port_pkg::TRF_BIT]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer engine
    // overall enable
    assign port_on     = port_enable && ctl.select_pin_enable;
    assign is_slave    = mode_clock_select[spi_port_pkg::MODE_SLAVE_BIT];
    assign busy        = (state == spi_port_pkg::XFER_BUSY);
    // Edge select 1 captures on the leading edge, 0 on the trailing one
    assign cap_lead    = ctl.clock_edge_select;
    // slave needs select low before clocks count
    assign slave_armed = port_on && is_slave && !pin_level[2];
    // idle high when polarity is zero, so leading edge falls
    assign slave_lead  = ctl.clock_idle_polarity ? pin_rise[0] : pin_fall[0];
    assign slave_trail = ctl.clock_idle_polarity ? pin_fall[0] : pin_rise[0];
    assign lead_ev     = is_slave ? slave_lead  : (master_tick && !edge_cnt[0]);
    assign trail_ev    = is_slave ? slave_trail : (master_tick &&  edge_cnt[0]);
    // slave starts on the first leading external edge
    assign slave_go    = !busy && slave_armed && slave_lead;
    assign sample_ev   = (busy || slave_go) && (cap_lead ? lead_ev : trail_ev);
    assign launch_ev   = (busy || slave_go) && (cap_lead ? trail_ev : lead_ev);
    assign start       = data_write && !busy && port_on && !is_slave;
    assign collide     = data_write && busy;
    assign abort       = busy && is_slave && !slave_armed;
    assign done        = busy && (is_slave ? (sample_ev && bit_cnt == spi_port_pkg::LAST_BIT)
                                           : (trail_ev && edge_cnt == spi_port_pkg::LAST_EDGE));

    assign next_shift  = ctl.bit_order_select ? {shift_buffer[6:0], pin_level[1]}
                                              : {pin_level[1], shift_buffer[7:1]};
    assign head_bit    = ctl.bit_order_select ? shift_buffer[7] : shift_buffer[0];
    assign start_head  = ctl.bit_order_select ? pwdata_i[7] : pwdata_i[0];

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state <= spi_port_pkg::XFER_IDLE;
        end else begin
            case (state)
                spi_port_pkg::XFER_IDLE: begin
                    if (start || slave_go) state <= spi_port_pkg::XFER_BUSY;
                end
                spi_port_pkg::XFER_BUSY: begin
                    // disabling the port ends a transfer
                    if (done || abort || !port_on) state <= spi_port_pkg::XFER_IDLE;
                end
                default: state <= spi_port_pkg::XFER_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || !busy) begin
            edge_cnt <= 4'h0;
            bit_cnt  <= 3'h0;
        end else begin
            if (master_tick) edge_cnt <= edge_cnt + 4'h1;
            if (sample_ev)   bit_cnt  <= bit_cnt + 3'h1;
        end
        if (rst_n_i && slave_go && sample_ev) bit_cnt <= 3'h1;
    end

    // shift buffer and readable data register
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            shift_buffer        <= spi_port_pkg::RST_SHIFT_DATA;
            shift_data_register <= spi_port_pkg::RST_SHIFT_DATA;
        end else begin
            if (data_write && !busy) begin
                shift_buffer <= pwdata_i[7:0];
            end else if (sample_ev) begin
                shift_buffer <= next_shift;
            end
            if (done) begin
                shift_data_register <= sample_ev ? next_shift : shift_buffer;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers, all registered
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            serial_clock_pin_o    <= 1'b1;
            serial_clock_pin_oe_o <= 1'b0;
            select_pin_n_o        <= 1'b1;
            select_pin_n_oe_o     <= 1'b0;
        end else begin
            // idle clock level, toggled only while busy
            if (busy && !is_slave && master_tick) begin
                serial_clock_pin_o <= !serial_clock_pin_o;
            end else if (!busy) begin
                serial_clock_pin_o <= !ctl.clock_idle_polarity;
            end
            // slave or disabled leaves the clock undriven
            serial_clock_pin_oe_o <= port_on && !is_slave;
            // master pulls select low for its transfer
            select_pin_n_o        <= !((busy || start) && !is_slave);
            select_pin_n_oe_o     <= port_on && !is_slave;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            serial_out_pin_o    <= 1'b1;
            serial_out_pin_oe_o <= 1'b0;
        end else begin
            // output idles high; the first bit leads for leading capture
            if (start && cap_lead) begin
                serial_out_pin_o <= start_head;
            end else if (launch_ev) begin
                serial_out_pin_o <= head_bit;
            end else if (!busy && slave_armed && cap_lead) begin
                serial_out_pin_o <= head_bit;
            end else if (!busy && !start) begin
                serial_out_pin_o <= 1'b1;
            end
            // released when off, driven when on
            serial_out_pin_oe_o <= port_on;
        end
    end

endmodule : spi_master_slave_port

// ---- test/spi_port_checker.sv ----
// Port checker for the serial port block, bound onto its top module.
// Assumes one clock domain and the registered one-wait APB answer.
`timescale 1ns/1ns
module spi_port_checker (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic serial_clock_pin_o,
    input wire logic serial_clock_pin_oe_o,
    input wire logic serial_out_pin_o,
    input wire logic serial_out_pin_oe_o,
    input wire logic select_pin_n_o,
    input wire logic select_pin_n_oe_o,
    input wire logic irq_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////
    sequence s_req; psel_i && penable_i && !pready_o; endsequence
    sequence s_ans; pready_o ##1 !pready_o; endsequence
    property p_apb_ans; s_req |=> s_ans; endproperty
    property p_err; pslverr_o |-> pready_o; endproperty
    property p_idle_out; serial_out_pin_oe_o && select_pin_n_oe_o && select_pin_n_o
        && $past(select_pin_n_o) && $past(select_pin_n_o, 2) |-> serial_out_pin_o; endproperty
    property p_slave_clk; serial_clock_pin_oe_o |-> select_pin_n_oe_o; endproperty
    property p_release; !serial_out_pin_oe_o |-> !serial_clock_pin_oe_o && !select_pin_n_oe_o; endproperty
    // A flag drops after a software write, which also starts master transfers, or when a slave transfer starts
    property p_irq_hold; $fell(irq_o) |-> $past(pwrite_i) || $past(pwrite_i, 2); endproperty
    property p_clk_quiet; select_pin_n_oe_o && select_pin_n_o && $past(select_pin_n_o)
        && !$past(pready_o) && !$past(pready_o, 2) |-> $stable(serial_clock_pin_o); endproperty
    property p_sel_out; select_pin_n_oe_o && !select_pin_n_o |-> serial_out_pin_oe_o; endproperty
    a_apb_ans: assert property (p_apb_ans) else $error("apb answer timing");
    a_err: assert property (p_err) else $error("error without ready");
    a_idle_out: assert property (p_idle_out) else $error("idle data not high");
    a_slave_clk: assert property (p_slave_clk) else $error("clock driven in slave");
    a_release: assert property (p_release) else $error("pins not released");
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
    a_clk_quiet: assert property (p_clk_quiet) else $error("clock moved idle");
    a_sel_out: assert property (p_sel_out) else $error("select without data");
endmodule : spi_port_checker
bind spi_master_slave_port spi_port_checker u_chk (.*);

// ---- test/spi_far_slave.sv ----
// Far-side slave device for master-mode transfers.
// Assumes resolved clock and select wires; launch on leading edge.
`timescale 1ns/1ns
module spi_far_slave (
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic       mosi_i,
    input  wire logic       pol_i,
    input  wire logic       msb_i,
    input  wire logic [7:0] tx_i,
    output logic            miso_o,
    output logic      [7:0] rx_o
);
    int n = 0;
    initial miso_o = 1'b0;
    always @(sclk_i) begin
        if (!cs_n_i && sclk_i == pol_i) begin
            miso_o = tx_i[msb_i ? 7 - n : n];
        end else if (!cs_n_i) begin
            rx_o[msb_i ? 7 - n : n] = mosi_i;
            n = n + 1;
        end
    end
    // Released line shows no stale bit
    always @(posedge cs_n_i) begin
        n = 0;
        miso_o = ~miso_o;
    end
endmodule : spi_far_slave

// ---- test/tb_top.sv ----
// Self-checking bench for the serial port block.
// Assumes the far slave model and the bound port checker.
`timescale 1ns/1ns
module tb_top;
    localparam logic [7:0] A0 = spi_port_pkg::OFS_CONTROL_ZERO, A1 = spi_port_pkg::OFS_CONTROL_ONE;
    localparam logic [7:0] AD = spi_port_pkg::OFS_SHIFT_DATA;
    logic        sys_clk_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0, rerr;
    logic [7:0]  paddr = 0, tx = 0, d, c1, got, far_rx;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, sclk_o, sclk_oe, sdo, sdo_oe, cs_n_o, cs_oe, irq, miso;
    logic        msb = 0, pol = 0, tb_sclk = 1, tb_cs_n = 1, tb_mosi = 0, slv = 0;
    int          n_fail = 0, n_checks = 0;
    wire sclk = sclk_oe ? sclk_o : tb_sclk;
    wire cs_n = cs_oe ? cs_n_o : tb_cs_n;
    always #4 sys_clk_i = ~sys_clk_i;
    spi_master_slave_port uut (.sys_clk_i, .rst_n_i, .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .serial_clock_pin_i(sclk), .serial_clock_pin_o(sclk_o), .serial_clock_pin_oe_o(sclk_oe),
        .serial_in_pin_i(slv ? tb_mosi : miso), .serial_out_pin_o(sdo), .serial_out_pin_oe_o(sdo_oe),
        .select_pin_n_i(cs_n), .select_pin_n_o(cs_n_o), .select_pin_n_oe_o(cs_oe), .irq_o(irq));
    spi_far_slave far (.sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(sdo), .pol_i(pol), .msb_i(msb),
        .tx_i(tx), .miso_o(miso), .rx_o(far_rx));
    ////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk_i);
        psel <= 1; pwr <= w; paddr <= a; pwdata <= wd;
        @(posedge sys_clk_i);
        pen <= 1;
        do @(posedge sys_clk_i); while (pready !== 1'b1);
        rd = prdata; rerr = pslverr;
        psel <= 0; pen <= 0;
    endtask : apb
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic print_verdict;
        if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    initial begin
        #400000 n_fail++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge sys_clk_i);
        rst_n_i <= 1;
        for (int a = 0; a < 12; a += 4) begin apb(0, a, 0); chk(rd, 0); end // reset values
        apb(0, 8'hFC, 0); chk(rd, 0); chk(rerr, 1); // unmapped address
        for (int m = 0; m < 4; m++) begin
            {pol, msb} = m[1:0]; tx = 8'hA5 - m; d = 8'h5A + m;
            c1 = {2'h0, m[1], 1'b0, m[0], 3'h4};
            apb(1, A0, {m[2:0], 5'h00}); apb(1, A1, c1); apb(1, A0, {m[2:0], 5'h02});
            apb(1, AD, d); apb(1, AD, 8'hFF);
            apb(0, A1, 0); chk(rd[1:0], 2'h2);
            for (int i = 0; i < 5000 && irq !== 1'b1; i++) @(posedge sys_clk_i);
            chk(irq, 1); chk(far_rx, d);
            apb(0, AD, 0); chk(rd, tx);
            chk({sclk, sdo}, {~pol, 1'b1});
            apb(1, A1, c1 | 3); apb(0, A1, 0); chk(rd, c1 | 3);
            apb(1, A1, c1); apb(0, A1, 0); chk(rd, c1);
            apb(1, AD, 8'hFF); // lost byte written again
            for (int i = 0; i < 5000 && irq !== 1'b1; i++) @(posedge sys_clk_i);
            chk(far_rx, 8'hFF); apb(1, A1, c1);
        end
        apb(1, A1, 0); repeat (2) @(posedge sys_clk_i); chk({sclk_oe, sdo_oe, cs_oe}, 0);
        apb(1, A0, 8'h82); apb(1, A1, 8'h0C); apb(1, AD, 8'hC3); slv <= 1; tb_cs_n <= 0;
        repeat (8) @(posedge sys_clk_i);
        for (int i = 7; i >= 0; i--) begin
            @(posedge sys_clk_i); tb_sclk <= 0; tb_mosi <= d[i] ^ i[0];
            repeat (8) @(posedge sys_clk_i); got[i] = sdo; tb_sclk <= 1;
            repeat (7) @(posedge sys_clk_i);
        end
        repeat (10) @(posedge sys_clk_i);
        tb_cs_n <= 1;
        chk({got, sclk_oe, irq}, {8'hC3, 2'h1}); apb(0, AD, 0); chk(rd, d ^ 8'hAA);
        print_verdict();
    end
endmodule : tb_top
